/* rtl/crbc_pkg.sv */
// Constants and types of the restart and bootstrap control block
package crbc_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int unsigned CRBC_AW       = 4;
  localparam logic [3:0]  CRBC_CTRL_OFS = 4'h0;
  localparam logic [3:0]  CRBC_STAT_OFS = 4'h4;
  localparam logic [3:0]  CRBC_VEC_OFS  = 4'h8;
  localparam int unsigned CTRL_AUTO     = 0;     // Halt restarts enabled
  localparam int unsigned CTRL_SOFT     = 1;     // Write 1: boot request
  localparam logic        CTRL_AUTO_RST = 1'b1;
  localparam int unsigned ST_MAP        = 16;
  localparam int unsigned ST_FRESH      = 17;
  localparam int unsigned ST_STATE      = 18;    // Two bits
  localparam int unsigned ST_SAMPLED    = 20;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // ------------------------------------------------------------
  // Status word bits
  // ------------------------------------------------------------
  localparam int unsigned SW_RESTART    = 3;
  localparam int unsigned SW_AUTOBOOT   = 4;
  localparam int unsigned SW_HOLD       = 5;
  localparam int unsigned SW_ACPWR      = 6;
  localparam int unsigned SW_CONTINUE   = 7;
  localparam int unsigned SW_LOAD       = 8;
  localparam int unsigned SW_JEXIST     = 11;
  localparam int unsigned SW_JPOS       = 15;
  localparam logic [15:0] SW_RST        = 16'hFFFF;
  // ------------------------------------------------------------
  // Vector fetch
  // ------------------------------------------------------------
  localparam logic [14:0] VEC_ADDR      = 15'h7FFF;  // Octal 77777
  localparam logic [14:0] ALT_ADDR      = 15'h7FFE;  // Octal 77776
  localparam int unsigned VEC_FLO       = 8;
  localparam int unsigned VEC_FHI       = 14;
  localparam int unsigned VEC_MSB       = 15;
  localparam logic [15:0] VEC_RST       = 16'h0000;

  typedef enum logic [1:0] {
    CRBC_IDLE   = 2'h0,
    CRBC_DECIDE = 2'h1,
    CRBC_FETCH  = 2'h3,
    CRBC_LAUNCH = 2'h2
  } crbc_state_e;
endpackage : crbc_pkg

/* rtl/crbc_sync.sv */
// Two-stage synchroniser for a bundle of pin levels
`timescale 1ns/1ns
`default_nettype none
module crbc_sync #(
  parameter int unsigned W = 16
) (
  input  wire logic         aclk,     // Clock
  input  wire logic         aresetn,  // Sync reset, active low
  input  wire logic [W-1:0] rst_val,  // Constant level under reset
  input  wire logic [W-1:0] d,        // Asynchronous levels
  output logic      [W-1:0] q         // Synchronised levels
);
  logic [W-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= rst_val;
      q      <= rst_val;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule : crbc_sync
`default_nettype wire

/* rtl/crbc_top.sv */
// Restart and bootstrap decision logic with an AXI4-Lite register port
`timescale 1ns/1ns
`default_nettype none
module crbc_top
  import crbc_pkg::*;
(
  input  wire logic         aclk,          // Clock, 100 MHz
  input  wire logic         aresetn,       // Sync reset, active low
  input  wire logic [3:0]   awaddr,        // Write address
  input  wire logic [2:0]   awprot,        // Unused
  input  wire logic         awvalid,       // Write address valid
  output logic              awready,       // Write address ready
  input  wire logic [31:0]  wdata,         // Write data
  input  wire logic [3:0]   wstrb,         // Byte enables
  input  wire logic         wvalid,        // Write data valid
  output logic              wready,        // Write data ready
  output logic [1:0]        bresp,         // Write response
  output logic              bvalid,        // Write response valid
  input  wire logic         bready,        // Write response ready
  input  wire logic [3:0]   araddr,        // Read address
  input  wire logic [2:0]   arprot,        // Unused
  input  wire logic         arvalid,       // Read address valid
  output logic              arready,       // Read address ready
  output logic [31:0]       rdata,         // Read data
  output logic [1:0]        rresp,         // Read response
  output logic              rvalid,        // Read data valid
  input  wire logic         rready,        // Read data ready
  input  wire logic [15:0]  status_pins,   // Status word from the bus
  input  wire logic         status_strobe, // Refresh capture pulse
  input  wire logic         halted,        // Processor is halted
  input  wire logic         cpu_ref,       // Core mapped memory reference
  input  wire logic [14:0]  cpu_addr,      // Core reference address
  output logic              fetch_req,     // Vector fetch request
  output logic [14:0]       fetch_addr,    // Vector fetch address
  input  wire logic         fetch_ack,     // Fetch data valid pulse
  input  wire logic [15:0]  fetch_data,    // Fetched word
  output logic              jumper_word_select_n, // Jumper word select
  output logic              mapped_space_flag,    // Mapped space on
  output logic              boot_go,       // Boot start pulse
  output logic [15:0]       boot_vector,   // Boot jump address
  output logic              continue_go,   // Continue pulse
  output logic              stay_halted    // Halt kept pulse
);
  crbc_state_e st;
  logic [15:0] pins_s;
  logic [15:0] samp;
  logic        have_samp;
  logic        fresh;
  logic        pend;
  logic        soft_pend;
  logic        auto_en;
  logic        warm;
  logic        resume_prev;
  logic [1:0]  flush;
  logic        aw_got;
  logic        w_got;
  logic [3:0]  aw_a;
  logic [31:0] w_d;
  logic [3:0]  w_s;
  logic        halted_q;
  logic        hold;
  logic        manual;
  logic        go;
  logic        go_warm;
  logic        do_wr;
  logic        soft_wr;
  logic [31:0] rd_word;
  logic        rd_hit;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Address match for the jumper word location
  function automatic logic jhit(input logic [14:0] a,
                                input logic [15:0] s);
    jhit = a == (s[SW_JPOS] ? VEC_ADDR : ALT_ADDR);
  endfunction : jhit

  // Returned vector with forcing applied
  function automatic logic [15:0] vec_fix(input logic [15:0] d,
                                          input logic        jsel,
                                          input logic        wrm);
    vec_fix = d;
    if (jsel) begin
      vec_fix[VEC_FHI:VEC_FLO] = '0;
      vec_fix[VEC_MSB]         = 1'b1;
    end else if (wrm) begin
      vec_fix[VEC_MSB] = 1'b0;
    end
  endfunction : vec_fix

  // ------------------------------------------------------------
  // Status word capture
  // ------------------------------------------------------------
  crbc_sync #(.W(16)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rst_val (SW_RST),
    .d       (status_pins),
    .q       (pins_s)
  );

  // Latest refresh sample drives every decision; the synchroniser still
  // shows its reset level for two edges, so no capture before it flushes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flush     <= 2'h0;
      samp      <= SW_RST;
      have_samp <= 1'b0;
    end else begin
      flush <= {flush[0], 1'b1};
      if (status_strobe && flush[1]) begin
        samp      <= pins_s;
        have_samp <= 1'b1;
      end
    end
  end

  assign hold   = samp[SW_HOLD];
  assign manual = hold && !samp[SW_LOAD];

  // ------------------------------------------------------------
  // Restart decision
  // ------------------------------------------------------------
  // Outcome of the decide state
  always_comb begin
    go_warm = 1'b0;
    if (hold) begin
      go = !samp[SW_AUTOBOOT] || manual || soft_pend;
    end else if (fresh) begin
      go = !samp[SW_RESTART];
    end else begin
      go      = 1'b1;
      go_warm = 1'b1;
    end
  end

  // Sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= CRBC_IDLE;
    end else begin
      case (st)
        CRBC_IDLE: begin
          if (halted && have_samp && (fresh || pend || manual || soft_pend))
            st <= CRBC_DECIDE;
        end
        CRBC_DECIDE: st <= go ? CRBC_FETCH : CRBC_IDLE;
        CRBC_FETCH: begin
          if (fetch_ack)
            st <= CRBC_LAUNCH;
        end
        CRBC_LAUNCH: st <= CRBC_IDLE;
        default: st <= CRBC_IDLE;
      endcase
    end
  end

  // Fresh power-up marker, known value at power-on
  always_ff @(posedge aclk) begin
    if (!aresetn)
      fresh <= 1'b1;
    else if (st == CRBC_DECIDE)
      fresh <= 1'b0;
  end

  // Pending restart requests; a new event beats the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halted_q  <= 1'b1;
      pend      <= 1'b0;
      soft_pend <= 1'b0;
    end else begin
      halted_q <= halted;
      if (halted && !halted_q && auto_en)
        pend <= 1'b1;
      else if (st == CRBC_DECIDE)
        pend <= 1'b0;
      if (soft_wr)
        soft_pend <= 1'b1;
      else if (st == CRBC_DECIDE)
        soft_pend <= 1'b0;
    end
  end

  // Mapped flag, warm marker and halt-kept pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mapped_space_flag <= 1'b0;
      warm              <= 1'b0;
      stay_halted       <= 1'b0;
    end else begin
      stay_halted <= (st == CRBC_DECIDE) && !go;
      if (st == CRBC_DECIDE && go) begin
        mapped_space_flag <= 1'b1;
        warm              <= go_warm;
      end
    end
  end

  // ------------------------------------------------------------
  // Vector fetch and jumper select
  // ------------------------------------------------------------
  assign fetch_req  = st == CRBC_FETCH;
  assign fetch_addr = VEC_ADDR;
  assign boot_go    = st == CRBC_LAUNCH;
  assign jumper_word_select_n = !(!samp[SW_JEXIST] &&
      ((fetch_req && jhit(fetch_addr, samp)) ||
       (cpu_ref && jhit(cpu_addr, samp))));

  // Vector register with forcing
  always_ff @(posedge aclk) begin
    if (!aresetn)
      boot_vector <= VEC_RST;
    else if (fetch_req && fetch_ack)
      boot_vector <= vec_fix(fetch_data, !jumper_word_select_n, warm);
  end

  // Continue switch, honoured only while hold is high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resume_prev <= 1'b1;
      continue_go <= 1'b0;
    end else begin
      resume_prev <= samp[SW_CONTINUE];
      continue_go <= halted && hold && resume_prev &&
                     !samp[SW_CONTINUE] && st == CRBC_IDLE;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  assign awready = !aw_got && !bvalid;
  assign wready  = !w_got && !bvalid;
  assign arready = !rvalid;
  assign do_wr   = aw_got && w_got && !bvalid;
  assign soft_wr = do_wr && aw_a == CRBC_CTRL_OFS && w_s[0] &&
                   w_d[CTRL_SOFT];

  // Write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
      aw_a   <= '0;
      w_d    <= '0;
      w_s    <= '0;
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        aw_a   <= awaddr;
      end
      if (wvalid && wready) begin
        w_got <= 1'b1;
        w_d   <= wdata;
        w_s   <= wstrb;
      end
      if (do_wr) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= (aw_a == CRBC_CTRL_OFS) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Control register
  always_ff @(posedge aclk) begin
    if (!aresetn)
      auto_en <= CTRL_AUTO_RST;
    else if (do_wr && aw_a == CRBC_CTRL_OFS && w_s[0])
      auto_en <= w_d[CTRL_AUTO];
  end

  // Read decode
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    case (araddr)
      CRBC_CTRL_OFS: rd_word[CTRL_AUTO] = auto_en;
      CRBC_STAT_OFS: begin
        rd_word[15:0]              = samp;
        rd_word[ST_MAP]            = mapped_space_flag;
        rd_word[ST_FRESH]          = fresh;
        rd_word[ST_STATE+1:ST_STATE] = st;
        rd_word[ST_SAMPLED]        = have_samp;
      end
      CRBC_VEC_OFS: rd_word[15:0] = boot_vector;
      default: rd_hit = 1'b0;
    endcase
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_decide_go;
    st == CRBC_DECIDE ##1 st == CRBC_FETCH;
  endsequence
  sequence s_fetch_done;
    st == CRBC_FETCH && fetch_ack;
  endsequence

  map_on_boot_a: assert property (s_decide_go |-> mapped_space_flag)
    else $error("mapped flag not set on boot");
  fresh_halt_a: assert property (st == CRBC_DECIDE && fresh && !hold &&
      samp[SW_RESTART] |=> st == CRBC_IDLE && stay_halted && !fresh)
    else $error("fresh power-up with restart high did not halt");
  warm_clear_a: assert property (s_fetch_done ##0 warm &&
      jumper_word_select_n |=> !boot_vector[VEC_MSB])
    else $error("warm boot vector bit 15 not cleared");
  fresh_drop_a: assert property ($fell(fresh) |->
      $past(st) == CRBC_DECIDE)
    else $error("power-up marker cleared outside decide");
  auto_boot_a: assert property (st == CRBC_DECIDE && hold &&
      !samp[SW_AUTOBOOT] |=> st == CRBC_FETCH ##[1:1000] boot_go)
    else $error("auto boot not started");
  jsel_addr_a: assert property (!jumper_word_select_n |->
      !samp[SW_JEXIST] && (fetch_req || cpu_ref))
    else $error("jumper select without jumper or reference");
  jumper_force_a: assert property (s_fetch_done ##0
      !jumper_word_select_n |=> boot_vector[VEC_MSB] &&
      boot_vector[VEC_FHI:VEC_FLO] == 7'h00 ##1 !boot_go)
    else $error("jumper vector bits not forced");
  hold_continue_switch_n_a: assert property (continue_go |-> $past(hold))
    else $error("continue honoured with hold low");
  sample_a: assert property (status_strobe && flush[1] |=>
      samp == $past(pins_s) && have_samp)
    else $error("status word not captured");
endmodule : crbc_top
`default_nettype wire

/* tb/crbc_panel.sv */
// Model of the panel switches, jumpers, supply and boot memory
`timescale 1ns/1ns
`default_nettype none
module crbc_panel #(
  parameter logic [15:0] MEM_WORD = 16'hC123  // Word held at the vector
) (
  input  wire logic        aclk,          // Clock
  input  wire logic [15:0] word,          // Switch and jumper levels
  input  wire logic        slow,          // Answer fetches late
  input  wire logic        fetch_req,     // Vector fetch request
  input  wire logic [14:0] fetch_addr,    // Vector fetch address
  output logic      [15:0] status_pins,   // Status word levels
  output logic             status_strobe, // Refresh capture pulse
  output logic             fetch_ack,     // Fetch data valid
  output logic      [15:0] fetch_data     // Fetched word
);
  logic [2:0] ref_cnt;
  logic [3:0] dly;
  initial begin
    ref_cnt = 3'h0;
    dly = 4'h0;
    status_pins = 16'hFFFF;
    status_strobe = 1'b0;
    fetch_ack = 1'b0;
    fetch_data = 16'h0000;
  end
  // ------------------------------------------------------------
  // Status word offered at every refresh
  // ------------------------------------------------------------
  // Hold, load and power-good levels come from the panel word
  always @(posedge aclk) begin
    ref_cnt <= ref_cnt + 3'h1;
    status_strobe <= (ref_cnt == 3'h7);
    status_pins <= word;
  end
  // ------------------------------------------------------------
  // Boot memory answers, data scrambled when not valid
  // ------------------------------------------------------------
  always @(posedge aclk) begin
    fetch_ack <= 1'b0;
    fetch_data <= ~fetch_data;
    if (fetch_req && !fetch_ack) begin
      if (dly >= (slow ? 4'h5 : 4'h0)) begin
        fetch_ack <= 1'b1;
        fetch_data <= (fetch_addr == 15'h7FFF) ? MEM_WORD : 16'h0000;
        dly <= 4'h0;
      end else begin
        dly <= dly + 4'h1;
      end
    end
  end
endmodule : crbc_panel
`default_nettype wire

/* tb/crbc_top_test.sv */
// Self-checking bench of the restart and bootstrap control block
`timescale 1ns/1ns
`default_nettype none
module crbc_top_test;
  import crbc_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata;
  logic awready, wready, bvalid, arready, rvalid, fetch_req, fetch_ack;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] status_pins, fetch_data, boot_vector, word;
  logic status_strobe, halted, cpu_ref, slow, jsel_n, map_flag;
  logic boot_go, continue_go, stay_halted;
  logic [14:0] cpu_addr, fetch_addr;
  int n_errors, check_count, cyc;
  bit seen_boot, seen_stay, seen_jsel;
  logic [1:0] resp;
  logic [31:0] rd;
  localparam logic [15:0] DATA = 16'hC123;
  crbc_top crbc_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .status_pins(status_pins),
    .status_strobe(status_strobe), .halted(halted), .cpu_ref(cpu_ref),
    .cpu_addr(cpu_addr), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_ack(fetch_ack), .fetch_data(fetch_data),
    .jumper_word_select_n(jsel_n), .mapped_space_flag(map_flag),
    .boot_go(boot_go), .boot_vector(boot_vector),
    .continue_go(continue_go), .stay_halted(stay_halted));
  crbc_panel crbc_panel_inst (.aclk(aclk), .word(word), .slow(slow),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .status_pins(status_pins), .status_strobe(status_strobe),
    .fetch_ack(fetch_ack), .fetch_data(fetch_data));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic finish_test;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, exp, input string msg);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h", $time, msg, got);
    end
  endtask : chk
  task automatic do_reset(input logic [15:0] w);
    word <= w;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset
  // Master samples each ready at the rising edge that takes the item
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    bit ta, tw, tb;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      ta = awvalid && awready; tw = wvalid && wready; tb = bvalid;
      resp = bresp;
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a);
    bit ta, tr;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge aclk);
      ta = arvalid && arready; tr = rvalid;
      resp = rresp; rd = rdata;
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        break;
      end
    end
  endtask : axi_rd
  // Runs until the block boots or stays halted, noting jumper select
  task automatic run_decision;
    seen_boot = 0; seen_stay = 0; seen_jsel = 0;
    repeat (300) begin
      @(posedge aclk);
      #1;
      if (fetch_req === 1'b1 && jsel_n === 1'b0) seen_jsel = 1;
      if (boot_go === 1'b1) seen_boot = 1;
      if (stay_halted === 1'b1) seen_stay = 1;
      if (seen_boot || seen_stay) break;
    end
  endtask : run_decision
  task automatic halt_again;
    repeat (30) @(posedge aclk);
    halted <= 1'b0;
    repeat (2) @(posedge aclk);
    halted <= 1'b1;
  endtask : halt_again
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Fresh power-up, hold low, restart high: halt is kept
  task automatic t_fresh_stay;
    do_reset(16'hFFDF);
    run_decision();
    chk(seen_stay, 1, "fresh restart high not kept halted");
    chk(map_flag, 0, "mapped flag set without boot");
    axi_rd(CRBC_STAT_OFS);
    chk(rd[ST_FRESH], 0, "fresh marker not cleared");
    chk(rd[15:0], 32'hFFDF, "sampled word wrong");
  endtask : t_fresh_stay
  // Warm halt, hold low: boot with vector bit 15 cleared
  task automatic t_warm_boot;
    halt_again();
    run_decision();
    chk(seen_boot, 1, "warm halt did not boot");
    chk(boot_vector, {1'b0, DATA[14:0]}, "warm vector bit 15");
    chk(map_flag, 1, "mapped flag not set");
  endtask : t_warm_boot
  // Fresh power-up, restart low: boot keeps bit 15
  task automatic t_fresh_boot;
    do_reset(16'hFFD7);
    run_decision();
    chk(seen_boot, 1, "fresh restart low did not boot");
    chk(boot_vector, DATA, "fresh vector altered");
    chk(map_flag, 1, "mapped flag not set");
  endtask : t_fresh_boot
  // Hold high, auto jumper low, jumper word present, slow memory
  task automatic t_auto_jumper;
    slow <= 1'b1;
    word <= 16'hF7EF;
    halt_again();
    run_decision();
    chk(seen_boot, 1, "auto boot on halt missing");
    chk(seen_jsel, 1, "jumper select not low at fetch");
    chk(boot_vector, {8'h80, DATA[7:0]}, "jumper vector forcing");
  endtask : t_auto_jumper
  // Jumper position low selects the other mapped location
  task automatic t_alt_select;
    word <= 16'h77EF;
    repeat (30) @(posedge aclk);
    cpu_ref <= 1'b1;
    cpu_addr <= ALT_ADDR;
    @(posedge aclk);
    #1;
    chk(jsel_n, 0, "select missing at alternate address");
    cpu_addr <= VEC_ADDR;
    @(posedge aclk);
    #1;
    chk(jsel_n, 1, "select at wrong address");
    cpu_ref <= 1'b0;
  endtask : t_alt_select
  // Register access, unmapped and read-only places refused
  task automatic t_regs;
    axi_rd(CRBC_CTRL_OFS);
    chk(rd, 32'h1, "control reset value");
    chk(resp, RESP_OKAY, "control read response");
    axi_rd(4'hC);
    chk(resp, RESP_SLVERR, "unmapped read response");
    axi_wr(CRBC_STAT_OFS, 32'h0);
    chk(resp, RESP_SLVERR, "read-only write response");
    axi_rd(CRBC_VEC_OFS);
    chk(rd, {16'h0, 8'h80, DATA[7:0]}, "vector register");
  endtask : t_regs
  // Continue gated by hold, soft request, manual load, auto enable off
  task automatic t_continue_switch_n_soft;
    bit seen_continue_switch_n;
    seen_continue_switch_n = 0;
    word <= 16'hF74F;
    repeat (40) @(posedge aclk) if (continue_go === 1'b1) seen_continue_switch_n = 1;
    chk(seen_continue_switch_n, 0, "continue honoured with hold low");
    word <= 16'hF7EF;
    repeat (40) @(posedge aclk);
    word <= 16'hF76F;
    repeat (40) @(posedge aclk) if (continue_go === 1'b1) seen_continue_switch_n = 1;
    chk(seen_continue_switch_n, 1, "continue with hold high missing");
    axi_wr(CRBC_CTRL_OFS, 32'h3);
    chk(resp, RESP_OKAY, "control write response");
    run_decision();
    chk(seen_boot, 1, "soft boot request ignored");
    chk(boot_vector, {8'h80, DATA[7:0]}, "soft boot jumper vector");
    axi_rd(CRBC_CTRL_OFS);
    chk(rd, 32'h1, "control readback");
    word <= 16'hF6EF;
    run_decision();
    chk(seen_boot, 1, "manual load with hold high did not boot");
    word <= 16'hF7EF;
    repeat (40) @(posedge aclk);
    axi_wr(CRBC_CTRL_OFS, 32'h0);
    chk(resp, RESP_OKAY, "control clear response");
    halt_again();
    run_decision();
    chk(seen_boot || seen_stay, 0, "halt restarted with auto off");
  endtask : t_continue_switch_n_soft
  // ------------------------------------------------------------
  // Clock, timeout and main sequence
  // ------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge aclk);
      cyc++;
      if (cyc == 20000) begin
        n_errors++;
        finish_test();
      end
    end
  end
  initial begin
    n_errors = 0; check_count = 0; aresetn = 1'b0; word = 16'hFFFF;
    awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; awvalid = 1'b0;
    wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    halted = 1'b1; cpu_ref = 1'b0; cpu_addr = 15'h0; slow = 1'b0;
    t_fresh_stay();
    t_warm_boot();
    t_fresh_boot();
    t_auto_jumper();
    t_alt_select();
    t_regs();
    t_continue_switch_n_soft();
    finish_test();
  end
endmodule : crbc_top_test
`default_nettype wire
